//--- rtl/dsoc_map.svh
// Constants for the deserializer output conditioning and link self-test block.
// Assumes inclusion by bare name from the package and the top module.
// Operation
// - Hold-low forces data, control and clock outputs low; lock output unaffected.
// - Hold-low release needs a set/reset bit toggle while lock is high.
// - With hold-low enabled, a falling lock re-enters the held-low state.
// - Manual clearing of the hold-low set condition only while lock is high.
// - Hold-low strap enabled makes the output-state select ignored.
// - Outputs stay high impedance until power_down_n goes high.
// - Edge select high launches for rising-edge strobe, low for falling edge.
// - Enabled filter removes control pulses of one or two clock periods.
// - Filter enabled by mode strap or by register setting.
// - Straps sampled at power-up; unconnected strap reads low.
// - Self-test checks payloads against PRBS-7 and flags errored payloads.
// - During self-test data outputs show an alternating checkerboard.
// - Each payload with 1 to 24 errors pulses result low half a clock.
// - Self-test enable falling latches result: high clean, low errored.
// - Latched result holds until new test, reset or power down.
// - Test pattern plus command codes from sender shut data/control outputs off.
// - Lock goes low when embedded clock bits fail to reconstruct clock.
// - Powered with static input: lock low, result keeps its latched value; data per state select.
`ifndef DSOC_MAP_SVH
`define DSOC_MAP_SVH
`define DSOC_AXI_CTRL 4'h0
`define DSOC_AXI_STAT 4'h4
`define DSOC_AXI_ERRS 4'h8
`define DSOC_CTRL_HOLD_TGL 0
`define DSOC_CTRL_FILT_EN 1
`define DSOC_CTRL_REG_OVR 2
`define DSOC_CTRL_EDGE 3
`define DSOC_CTRL_OSS 4
`define DSOC_CTRL_RST 32'h0000_0000
`define DSOC_CHECKER 24'hAAAAAA
`define DSOC_FILT_LEN 3
`define DSOC_MAX_ERRS 24
`define DSOC_PRBS_TAP_A 6
`define DSOC_PRBS_TAP_B 5
`define DSOC_RESP_OKAY 2'h0
`define DSOC_RESP_SLVERR 2'h2
`endif

//--- rtl/dsoc_pkg.sv
// Types shared by the output conditioning and self-test block.
// Assumes dsoc_map.svh sits on the include path.
package dsoc_pkg;
`include "dsoc_map.svh"
   typedef struct packed {
      logic [23:0] data;
      logic [2:0] ctrl;
      logic clk;
   } dsoc_par_t;
   typedef struct packed {
      logic hold_low;
      logic mode_filter;
      logic oss;
      logic edge_sel;
   } dsoc_strap_t;
   typedef enum logic [2:0] {
      DSOC_IDLE = 3'b001,
      DSOC_SEED = 3'b010,
      DSOC_RUN = 3'b100
   } dsoc_bist_t;
endpackage : dsoc_pkg

//--- rtl/dsoc_top.sv
// Output conditioning and PRBS-7 link self-test checker on the recovered clock.
// Assumes a CDR upstream delivering payload, control, lock and embedded clock bits.
`timescale 1ns/10ps
`include "dsoc_map.svh"
module dsoc_top
   import dsoc_pkg::*;
#(
   parameter int DATA_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic serial_active,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic [2:0] rx_ctrl,
   input wire logic embedded_clock_bit_low,
   input wire logic embedded_clock_bit_high,
   input wire logic selftest_command_a,
   input wire logic selftest_command_b,
   input wire logic selftest_enable,
   input wire dsoc_strap_t strap_in,
   input wire logic output_edge_select,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [DATA_W-1:0] data_out,
   output logic [2:0] control_outputs,
   output logic recovered_clock_out,
   output logic outputs_oe,
   output logic lock,
   output logic lock_oe,
   output logic pass,
   output logic pass_oe
);
   if (DATA_W != `DSOC_MAX_ERRS) begin : g_bad_width
      $error("DATA_W must equal 24");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode for the three registers, shared by both bus paths
   function automatic logic [1:0] dsoc_dec(input logic [3:0] a);
      if (a == `DSOC_AXI_CTRL) dsoc_dec = 2'h1;
      else if (a == `DSOC_AXI_STAT) dsoc_dec = 2'h2;
      else if (a == `DSOC_AXI_ERRS) dsoc_dec = 2'h3;
      else dsoc_dec = 2'h0;
   endfunction : dsoc_dec

   // PRBS-7 next word: 24 steps of x^7+x^6+1
   function automatic logic [6:0] dsoc_prbs(input logic [6:0] s);
      logic [6:0] t;
      t = s;
      for (int i = 0; i < DATA_W; i++) t = {t[5:0], t[`DSOC_PRBS_TAP_A] ^ t[`DSOC_PRBS_TAP_B]};
      dsoc_prbs = t;
   endfunction : dsoc_prbs

   function automatic logic [DATA_W-1:0] dsoc_expand(input logic [6:0] s);
      logic [6:0] t;
      logic [DATA_W-1:0] w;
      t = s;
      w = '0;
      for (int i = 0; i < DATA_W; i++) begin
         w[DATA_W-1-i] = t[`DSOC_PRBS_TAP_A];
         t = {t[5:0], t[`DSOC_PRBS_TAP_A] ^ t[`DSOC_PRBS_TAP_B]};
      end
      dsoc_expand = w;
   endfunction : dsoc_expand

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave state
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [3:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [31:0] ctrl, next_ctrl;
   logic [1:0] next_bresp, next_rresp;
   logic next_bvalid, next_rvalid;
   logic [31:0] next_rdata;
   logic [15:0] err_count, next_err_count;
   logic wr_go;

   // Status wires feeding readback
   logic hold_active, bist_result, locked;
   dsoc_bist_t bist_state;
   dsoc_strap_t straps;

   // Address and data captured independently, write fires once both held
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_ctrl = ctrl;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         for (int b = 0; b < 4; b++) if (s_axi_wstrb[b]) next_w_data[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `DSOC_RESP_OKAY;
         if (dsoc_dec(aw_addr) == 2'h1) next_ctrl = w_data;
         else if (dsoc_dec(aw_addr) == 2'h0) next_bresp = `DSOC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = `DSOC_RESP_OKAY;
         if (dsoc_dec(s_axi_araddr) == 2'h1) next_rdata = ctrl;
         else if (dsoc_dec(s_axi_araddr) == 2'h2)
            next_rdata = {24'h0, straps, bist_state == DSOC_RUN, bist_result, hold_active, locked};
         else if (dsoc_dec(s_axi_araddr) == 2'h3) next_rdata = {16'h0, err_count};
         else begin
            next_rdata = 32'h0;
            next_rresp = `DSOC_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Ready is registered; awready and wready come from the next held flags, arready from next_rvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         ctrl <= `DSOC_CTRL_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DSOC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `DSOC_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         ctrl <= next_ctrl;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
         s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Straps, lock and hold-low
   logic pd_seen, next_pd_seen, hold_tgl_q, next_hold_tgl_q;
   logic next_hold_active, next_locked;
   dsoc_strap_t next_straps;
   logic filt_en, edge_sel, oss_eff;

   // Register override wins over the mode strap and the edge select pin once software sets it
   assign filt_en = ctrl[`DSOC_CTRL_REG_OVR] ? ctrl[`DSOC_CTRL_FILT_EN] : straps.mode_filter;
   assign edge_sel = ctrl[`DSOC_CTRL_REG_OVR] ? ctrl[`DSOC_CTRL_EDGE] : output_edge_select;
   // Hold-low strap makes state select meaningless; treat as drive-low
   assign oss_eff = straps.hold_low ? 1'b0 : (ctrl[`DSOC_CTRL_REG_OVR] ? ctrl[`DSOC_CTRL_OSS] : straps.oss);

   always_comb begin
      next_pd_seen = power_down_n;
      next_straps = straps;
      // Straps taken on the first powered cycle; pads have pulldowns so X-free low
      if (power_down_n && !pd_seen) next_straps = strap_in;
      // Lock needs both embedded clock bits to reconstruct the clock edge
      next_locked = power_down_n && serial_active && embedded_clock_bit_high && !embedded_clock_bit_low;
      next_hold_tgl_q = ctrl[`DSOC_CTRL_HOLD_TGL];
      next_hold_active = hold_active;
      if (power_down_n && !pd_seen) next_hold_active = strap_in.hold_low;
      else if (!straps.hold_low) next_hold_active = 1'b0;
      else if (locked && !next_locked) next_hold_active = 1'b1;
      // Toggle of set/reset bit only counts while locked
      else if (locked && (ctrl[`DSOC_CTRL_HOLD_TGL] != hold_tgl_q)) next_hold_active = !hold_active;
      if (!power_down_n) next_hold_active = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_seen <= 1'b0;
         straps <= '0;
         locked <= 1'b0;
         hold_tgl_q <= 1'b0;
         hold_active <= 1'b0;
      end else begin
         pd_seen <= next_pd_seen;
         straps <= next_straps;
         locked <= next_locked;
         hold_tgl_q <= next_hold_tgl_q;
         hold_active <= next_hold_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control glitch filter: new level must persist three cycles
   logic [2:0] filt_q, next_filt_q;
   logic [2:0][1:0] filt_cnt, next_filt_cnt;

   for (genvar g = 0; g < 3; g++) begin : g_filt
      always_comb begin
         next_filt_cnt[g] = 2'h0;
         next_filt_q[g] = filt_q[g];
         if (rx_ctrl[g] != filt_q[g]) begin
            next_filt_cnt[g] = filt_cnt[g] + 2'h1;
            if (filt_cnt[g] == 2'(`DSOC_FILT_LEN - 1)) begin
               next_filt_q[g] = rx_ctrl[g];
               next_filt_cnt[g] = 2'h0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_q <= 3'h0;
         filt_cnt <= '0;
      end else begin
         filt_q <= next_filt_q;
         filt_cnt <= next_filt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-test checker
   logic [6:0] prbs, next_prbs;
   logic bist_q, next_bist_q, next_bist_result, next_err_pulse;
   dsoc_bist_t next_bist_state;
   logic [DATA_W-1:0] diff;
   logic [4:0] err_bits;

   assign diff = rx_data ^ dsoc_expand(prbs);

   always_comb begin
      err_bits = 5'h0;
      for (int i = 0; i < DATA_W; i++) err_bits = err_bits + 5'(diff[i]);
      next_bist_q = selftest_enable;
      next_bist_state = bist_state;
      next_prbs = prbs;
      next_bist_result = bist_result;
      next_err_pulse = 1'b0;
      next_err_count = err_count;
      case (bist_state)
         DSOC_IDLE: begin
            if (selftest_enable && !bist_q) begin
               next_bist_state = DSOC_SEED;
               next_bist_result = 1'b1;
               next_err_count = 16'h0;
            end
         end
         DSOC_SEED: begin
            // Seed from the top of the first payload so alignment is free
            next_prbs = dsoc_prbs(rx_data[DATA_W-1 -: 7]);
            next_bist_state = DSOC_RUN;
            if (!selftest_enable) next_bist_state = DSOC_IDLE;
         end
         DSOC_RUN: begin
            next_prbs = dsoc_prbs(prbs);
            if (err_bits != 5'h0 && err_bits <= 5'(`DSOC_MAX_ERRS)) begin
               next_err_pulse = 1'b1;
               next_bist_result = 1'b0;
               next_err_count = err_count + 16'h1;
            end
            if (!selftest_enable) next_bist_state = DSOC_IDLE;
         end
         default: next_bist_state = DSOC_IDLE;
      endcase
      if (!power_down_n) next_bist_result = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bist_state <= DSOC_IDLE;
         prbs <= 7'h7F;
         bist_q <= 1'b0;
         bist_result <= 1'b0;
         err_count <= 16'h0;
      end else begin
         bist_state <= next_bist_state;
         prbs <= next_prbs;
         bist_q <= next_bist_q;
         bist_result <= next_bist_result;
         err_count <= next_err_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stage; every pin is a flop, clock out is the phase flop
   dsoc_par_t next_par;
   logic next_oe, next_lock_oe, next_pass, clk_phase, next_clk_phase;
   logic test_mode;

   // Pattern with command codes means the sender is testing, so mute data and control outputs
   assign test_mode = selftest_command_a && selftest_command_b;

   always_comb begin
      next_clk_phase = !clk_phase;
      next_par.data = rx_data;
      next_par.ctrl = filt_en ? filt_q : rx_ctrl;
      // Falling-edge strobe inverts the launched clock phase
      next_par.clk = edge_sel ? next_clk_phase : !next_clk_phase;
      next_oe = pd_seen && power_down_n;
      next_lock_oe = power_down_n;
      // One aclk low per errored payload, half a clock-out period, so none is lost
      next_pass = (bist_state == DSOC_RUN) ? !next_err_pulse : bist_result;
      if (test_mode) begin
         next_par.data = '0;
         next_par.ctrl = 3'h0;
      end
      if (bist_state != DSOC_IDLE) next_par.data = `DSOC_CHECKER ^ {DATA_W{clk_phase}};
      if (!locked) begin
         next_par = '0;
         if (oss_eff) next_oe = 1'b0;
         next_pass = (bist_state == DSOC_IDLE) ? bist_result : 1'b0;
      end
      if (hold_active) next_par = '0;
      if (!power_down_n) next_pass = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_phase <= 1'b0;
         data_out <= '0;
         control_outputs <= 3'h0;
         recovered_clock_out <= 1'b0;
         outputs_oe <= 1'b0;
         lock <= 1'b0;
         lock_oe <= 1'b0;
         pass <= 1'b0;
         pass_oe <= 1'b0;
      end else begin
         clk_phase <= next_clk_phase;
         data_out <= next_par.data;
         control_outputs <= next_par.ctrl;
         recovered_clock_out <= next_par.clk;
         outputs_oe <= next_oe;
         lock <= locked; // lock unaffected by hold-low
         lock_oe <= next_lock_oe;
         pass <= next_pass;
         pass_oe <= next_lock_oe;
      end
   end
endmodule : dsoc_top

//--- verif/dsoc_properties.sv
// Port-level checks for the output conditioning and self-test block.
// Assumes it is bound into dsoc_top and sees only that module's ports.
`timescale 1ns/10ps
module dsoc_properties
   import dsoc_pkg::*;
#(
   parameter int DATA_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic serial_active,
   input wire logic embedded_clock_bit_low,
   input wire logic embedded_clock_bit_high,
   input wire logic selftest_enable,
   input wire dsoc_strap_t strap_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic [2:0] control_outputs,
   input wire logic recovered_clock_out,
   input wire logic outputs_oe,
   input wire logic lock,
   input wire logic lock_oe,
   input wire logic pass,
   input wire logic pass_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic link_ok;
   // Clock bits only count on a powered, toggling link
   assign link_ok = embedded_clock_bit_high && !embedded_clock_bit_low && power_down_n && serial_active;
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   a_unpowered_hiz: assert property (!power_down_n && $past(aresetn) |=> !outputs_oe && !lock_oe && !pass_oe)
      else $error("outputs enabled while powered down");
   a_powered_oe: assert property (power_down_n && $past(aresetn) |=> lock_oe && pass_oe)
      else $error("lock or result not driven while powered");
   // Two bad cycles cover a lock path of one or two stages
   a_lock_needs_clock: assert property ((!link_ok && $past(aresetn)) ##1 !link_ok |=> !lock)
      else $error("lock high without valid clock bits");
   a_static_lock_low: assert property (power_down_n && !serial_active ##1 !serial_active |=> !lock)
      else $error("lock high on a static input");
   a_hold_unlocked: assert property (
      (power_down_n && strap_in.hold_low && !lock && !selftest_enable) [*4]
      |-> data_out == '0 && control_outputs == 3'h0 && !recovered_clock_out)
      else $error("outputs released while unlocked with hold enabled");
   a_error_pulse: assert property (selftest_enable && $past(selftest_enable) && $fell(pass) |=> pass)
      else $error("error flag longer than one cycle");
   // Latching may take two cycles after the enable falls, so wait five
   a_result_holds: assert property (
      (!selftest_enable && power_down_n) [*5] ##0 $past(aresetn, 5) |-> $stable(pass))
      else $error("latched result changed");
   a_checker_data: assert property (
      (selftest_enable && power_down_n && !strap_in.hold_low) [*4]
      |-> data_out == 24'hAAAAAA || data_out == 24'h555555)
      else $error("data not a checkerboard during self-test");
endmodule : dsoc_properties

bind dsoc_top dsoc_properties #(.DATA_W(DATA_W)) u_props (.aclk, .aresetn, .power_down_n, .serial_active,
   .embedded_clock_bit_low, .embedded_clock_bit_high, .selftest_enable, .strap_in, .data_out,
   .control_outputs, .recovered_clock_out, .outputs_oe, .lock, .lock_oe, .pass, .pass_oe);

//--- verif/dsoc_ser_model.sv
// Behavioural far-end serializer: payload, control, clock bits, test pattern.
// Assumes the bench changes its inputs just after rising edges of aclk.
`timescale 1ns/10ps
module dsoc_ser_model (
   input wire logic aclk,
   input wire logic link_on,
   input wire logic bist_on,
   input wire logic err_req,
   input wire logic [23:0] par_data,
   input wire logic [2:0] par_ctrl,
   output logic serial_active,
   output logic [23:0] rx_data,
   output logic [2:0] rx_ctrl,
   output logic embedded_clock_bit_low,
   output logic embedded_clock_bit_high,
   output logic selftest_command_a,
   output logic selftest_command_b
);
   logic [6:0] st = 7'h7F;
   logic [23:0] dq = 24'h0;
   logic [2:0] cq = 3'h0;
   logic act = 1'b0;
   logic cmd = 1'b0;
   // Next 24 bits of the PRBS-7 stream, oldest bit in the top position
   function automatic logic [30:0] prbs24(input logic [6:0] s);
      logic [23:0] w;
      for (int i = 23; i >= 0; i--) begin
         w[i] = s[6];
         s = {s[5:0], s[6] ^ s[5]};
      end
      return {s, w};
   endfunction : prbs24
   // A dead link shows no stale value: lines invert each cycle
   always @(posedge aclk) begin
      act <= link_on;
      cmd <= link_on && (bist_on || ~|par_data);
      cq <= link_on ? par_ctrl : ~cq;
      if (!link_on) begin
         dq <= ~dq;
      end else if (bist_on || ~|par_data) begin
         {st, dq} <= prbs24(st) ^ {30'h0, err_req};
      end else begin
         dq <= par_data;
      end
   end
   assign serial_active = act;
   assign rx_data = dq;
   assign rx_ctrl = cq;
   assign embedded_clock_bit_high = act;
   assign embedded_clock_bit_low = 1'b0;
   assign selftest_command_a = cmd;
   assign selftest_command_b = cmd;
endmodule : dsoc_ser_model

//--- verif/dsoc_top_tb.sv
// Bench: AXI4-Lite register tasks plus link stimulus through the serializer model.
// Assumes dsoc_top at its default width and dsoc_ser_model on the far side.
`timescale 1ns/10ps
`include "dsoc_map.svh"
module dsoc_top_tb
   import dsoc_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, power_down_n = 1'b0, selftest_enable = 1'b0;
   logic output_edge_select = 1'b0, link_on = 1'b0, bist_on = 1'b0, err_req = 1'b0;
   dsoc_strap_t strap_in = 4'hC;
   logic [23:0] par_data = 24'h5A3C96, rx_data, data_out;
   logic [2:0] par_ctrl = 3'h0, rx_ctrl, control_outputs;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_active;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic embedded_clock_bit_low, embedded_clock_bit_high, selftest_command_a, selftest_command_b;
   logic recovered_clock_out, outputs_oe, lock, lock_oe, pass, pass_oe;
   int num_errors = 0, check_count = 0, lows;
   dsoc_ser_model u_ser (.aclk, .link_on, .bist_on, .err_req, .par_data, .par_ctrl, .serial_active, .rx_data,
      .rx_ctrl, .embedded_clock_bit_low, .embedded_clock_bit_high, .selftest_command_a, .selftest_command_b);
   dsoc_top dut (.aclk, .aresetn, .power_down_n, .serial_active, .rx_data, .rx_ctrl, .embedded_clock_bit_low,
      .embedded_clock_bit_high, .selftest_command_a, .selftest_command_b, .selftest_enable, .strap_in,
      .output_edge_select, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_out, .control_outputs,
      .recovered_clock_out, .outputs_oe, .lock, .lock_oe, .pass, .pass_oe);
   // 100 MHz clock
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic timed_out();
      num_errors++;
      $display("BAD %0t wait ran out", $time);
      end_of_test();
   endtask : timed_out
   // Write: address and data offered together, each dropped once taken
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (++n > 50) timed_out();
      end while (!s_axi_bvalid);
      check(32'(s_axi_bresp), 32'(`DSOC_RESP_OKAY));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (++n > 50) timed_out();
      end while (!s_axi_rvalid);
      check(s_axi_rdata & m, e);
      check(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : reg_rd
   function automatic logic [31:0] view(input int sel);
      case (sel)
         0: return 32'(data_out);
         1: return 32'(control_outputs);
         2: return {30'h0, lock, outputs_oe};
         default: return {31'h0, pass};
      endcase
   endfunction : view
   // Wait up to 12 cycles for a value, or with keep set demand it every cycle
   task automatic await(input int sel, input logic [31:0] e, input bit keep);
      for (int n = 0; n < 12; n++) begin
         @(posedge aclk);
         if (keep) check(view(sel), e);
         else if (view(sel) === e) break;
      end
      if (!keep) check(view(sel), e);
   endtask : await
   task automatic ctrl_pulse(input int w);
      par_ctrl <= 3'h1;
      repeat (w) @(posedge aclk);
      par_ctrl <= 3'h0;
   endtask : ctrl_pulse
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Hang guard: well above the length of the whole sequence
   initial begin
      repeat (20000) @(posedge aclk);
      timed_out();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      await(2, 32'h0, 1);
      reg_rd(`DSOC_AXI_CTRL, 32'hFFFFFFFF, `DSOC_CTRL_RST, `DSOC_RESP_OKAY);
      reg_rd(4'hC, 32'hFFFFFFFF, 32'h0, `DSOC_RESP_SLVERR);
      power_down_n <= 1'b1;
      await(2, 32'h1, 0);
      reg_rd(`DSOC_AXI_STAT, 32'hF0, 32'hC0, `DSOC_RESP_OKAY);
      reg_wr(`DSOC_AXI_CTRL, 32'h14);
      await(2, 32'h1, 1);
      reg_wr(`DSOC_AXI_CTRL, 32'h0);
      $display("test power-up done");
      link_on <= 1'b1;
      await(2, 32'h3, 0);
      await(0, 32'h0, 1);
      reg_wr(`DSOC_AXI_CTRL, 32'h1);
      await(0, 32'h5A3C96, 0);
      link_on <= 1'b0;
      await(0, 32'h0, 0);
      reg_wr(`DSOC_AXI_CTRL, 32'h0);
      link_on <= 1'b1;
      await(2, 32'h3, 0);
      await(0, 32'h0, 1);
      reg_wr(`DSOC_AXI_CTRL, 32'h1);
      await(0, 32'h5A3C96, 0);
      $display("test hold done");
      ctrl_pulse(1);
      await(1, 32'h0, 1);
      ctrl_pulse(2);
      await(1, 32'h0, 1);
      par_ctrl <= 3'h1;
      await(1, 32'h1, 0);
      par_ctrl <= 3'h0;
      await(1, 32'h0, 0);
      reg_wr(`DSOC_AXI_CTRL, 32'h5);
      ctrl_pulse(1);
      await(1, 32'h1, 0);
      reg_wr(`DSOC_AXI_CTRL, 32'h1);
      $display("test filter done");
      link_on <= 1'b0;
      power_down_n <= 1'b0;
      strap_in <= 4'h2;
      await(2, 32'h0, 0);
      await(2, 32'h0, 1);
      power_down_n <= 1'b1;
      await(2, 32'h0, 1);
      reg_rd(`DSOC_AXI_STAT, 32'hF0, 32'h20, `DSOC_RESP_OKAY);
      link_on <= 1'b1;
      par_ctrl <= 3'h7;
      await(1, 32'h7, 0);
      bist_on <= 1'b1;
      await(1, 32'h0, 0);
      selftest_enable <= 1'b1;
      repeat (8) @(posedge aclk);
      check(32'(data_out === 24'hAAAAAA || data_out === 24'h555555), 32'h1);
      lows = 0;
      for (int i = 0; i < 40; i++) begin
         err_req <= (i == 10 || i == 25);
         @(posedge aclk);
         if (pass === 1'b0) lows++;
      end
      check(lows, 32'h2);
      selftest_enable <= 1'b0;
      await(3, 32'h0, 0);
      bist_on <= 1'b0;
      await(3, 32'h0, 1);
      reg_rd(`DSOC_AXI_ERRS, 32'hFFFFFFFF, 32'h2, `DSOC_RESP_OKAY);
      par_data <= 24'h0;
      repeat (4) @(posedge aclk);
      selftest_enable <= 1'b1;
      repeat (30) @(posedge aclk);
      selftest_enable <= 1'b0;
      await(3, 32'h1, 0);
      par_data <= 24'h5A3C96;
      await(3, 32'h1, 1);
      reg_rd(`DSOC_AXI_ERRS, 32'hFFFFFFFF, 32'h0, `DSOC_RESP_OKAY);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      await(3, 32'h0, 0);
      $display("test self-test done");
      end_of_test();
   end
endmodule : dsoc_top_tb
